// [rtl/can_mode_pkg.sv]
package can_mode_pkg;

  localparam int          LOCK_BITS       = 32;
  localparam int          STD_ID_W        = 11;
  localparam int          EXT_ID_W        = 18;
  localparam logic [1:0]  RECOV_WAIT      = 2'h0;
  localparam logic [1:0]  RECOV_AUTO_NOW  = 2'h1;
  localparam logic [1:0]  RECOV_AUTO_END  = 2'h2;
  localparam logic [1:0]  RECOV_REQ_NOW   = 2'h3;
  localparam logic [31:0] FILTER_RST      = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_OPER,
    MODE_RESET,
    MODE_HALT
  } op_mode_type;

  // Protocol-engine status sampled every cycle that ce_in is high
  typedef struct packed {
    logic bit_tick;
    logic rx_bit;
    logic receiving;
    logic transmitting;
    logic frame_done;
    logic bus_error;
    logic arb_lost;
    logic bus_idle;
    logic suspend_tx;
    logic busoff;
    logic recovery_done;
  } proto_stat_type;

  // Identifier and filter entry, standard part in the upper bits
  typedef struct packed {
    logic [STD_ID_W-1:0] std_id;
    logic [EXT_ID_W-1:0] ext_id;
  } can_id_type;

endpackage

// [rtl/can_mode_and_bus_lock_control.sv]
`timescale 1ns/100ps
module can_mode_and_bus_lock_control #(
  parameter int LOCK_COUNT = can_mode_pkg::LOCK_BITS
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        ce_in,
  input  wire logic                        can_rx_in,
  input  can_mode_pkg::proto_stat_type     stat_in,
  input  wire logic                        reset_req_in,
  input  wire logic                        halt_req_in,
  input  wire logic                        oper_req_in,
  input  wire logic [1:0]                  busoff_recovery_mode_in,
  input  wire logic                        force_busoff_recovery_in,
  input  wire logic                        bus_lock_clear_in,
  input  can_mode_pkg::can_id_type         rx_id_in,
  input  wire logic                        rx_id_valid_in,
  input  can_mode_pkg::can_id_type         filter_id_in,
  input  can_mode_pkg::can_id_type         filter_mask_in,
  output logic [1:0]                       op_mode_out,
  output logic                             bus_lock_flag_out,
  output logic                             force_recovery_out,
  output logic                             accept_out,
  output logic [7:0]                       ctrl_status_out
);
  import can_mode_pkg::*;

  localparam int CW = $clog2(LOCK_COUNT + 1);

  logic           rx_meta_q;
  logic           rx_sync_q;
  proto_stat_type stat_q;
  op_mode_type    mode_q;
  logic           reset_pend_q;
  logic           halt_pend_q;
  logic [CW-1:0]  dom_cnt_q;
  logic           lock_q;
  logic           armed_q;
  logic           wait_rearm_q;
  logic           saw_reset_q;
  logic           force_q;
  logic           accept_q;
  logic           in_frame;
  logic           frame_over;
  logic           locked;
  logic           go_reset;
  logic           go_halt;
  logic           busoff_halt;
  logic [STD_ID_W+EXT_ID_W-1:0] diff;

  // Bus pin synchroniser
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else if (ce_in) begin
      rx_meta_q <= can_rx_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_q <= '0;
    end else if (ce_in) begin
      stat_q <= stat_in;
    end
  end

  // Dominant run counter, counted only in operation mode
  // dominant run detect
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dom_cnt_q <= '0;
    end else if (ce_in) begin
      if (mode_q != MODE_OPER || rx_sync_q) begin
        dom_cnt_q <= '0;
      end else if (stat_q.bit_tick && dom_cnt_q < CW'(LOCK_COUNT)) begin
        dom_cnt_q <= dom_cnt_q + 1'b1;
      end
    end
  end

  // Flag set wins over a same-cycle clear
  // lock flag set
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_q <= 1'b0;
    end else if (ce_in) begin
      if (armed_q && mode_q == MODE_OPER && dom_cnt_q == CW'(LOCK_COUNT)) begin
        lock_q <= 1'b1;
      end else if (bus_lock_clear_in) begin
        lock_q <= 1'b0;
      end
    end
  end

  // Re-arm after clear: recessive bit, or reset then operation
  // recessive re-arm
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed_q      <= 1'b1;
      wait_rearm_q <= 1'b0;
      saw_reset_q  <= 1'b0;
    end else if (ce_in) begin
      if (armed_q && mode_q == MODE_OPER && dom_cnt_q == CW'(LOCK_COUNT)) begin
        armed_q      <= 1'b0;
        wait_rearm_q <= 1'b0;
        saw_reset_q  <= 1'b0;
      end else if (!armed_q && lock_q && bus_lock_clear_in) begin
        wait_rearm_q <= 1'b1;
      end else if (wait_rearm_q) begin
        if (mode_q == MODE_RESET) begin
          saw_reset_q <= 1'b1;
        end
        if (rx_sync_q || (saw_reset_q && mode_q == MODE_OPER)) begin
          armed_q      <= 1'b1;
          wait_rearm_q <= 1'b0;
          saw_reset_q  <= 1'b0;
        end
      end
    end
  end

  // Bus counted as locked while the dominant run persists
  assign locked     = (dom_cnt_q == CW'(LOCK_COUNT)) && !rx_sync_q;
  assign in_frame   = stat_q.receiving || stat_q.transmitting;
  // error or lost arbitration ends the wait
  assign frame_over = stat_q.frame_done || stat_q.bus_error || stat_q.arb_lost;

  assign go_reset = (reset_req_in || reset_pend_q) && (
                      stat_q.busoff ||
                      (!stat_q.transmitting && !stat_q.suspend_tx) ||
                      (stat_q.transmitting && frame_over) ||
                      (stat_q.suspend_tx && (stat_q.bus_idle || stat_q.receiving)));

  // rx error also ends the wait
  always_comb begin
    go_halt = 1'b0;
    if (halt_req_in || halt_pend_q) begin
      if (stat_q.busoff) begin
        case (busoff_recovery_mode_in)
          RECOV_WAIT:    go_halt = stat_q.recovery_done;
          RECOV_REQ_NOW: go_halt = 1'b1;
          default:       go_halt = 1'b0;
        endcase
      end else begin
        go_halt = !in_frame || frame_over;
      end
    end
  end

  assign busoff_halt = (busoff_recovery_mode_in == RECOV_AUTO_NOW && stat_q.busoff) ||
                       (busoff_recovery_mode_in == RECOV_AUTO_END && stat_q.busoff &&
                        stat_q.recovery_done);

  // Reset has priority over halt; reset requests are held until served, halt requests only while in operation mode
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q       <= MODE_RESET;
      reset_pend_q <= 1'b0;
      halt_pend_q  <= 1'b0;
    end else if (ce_in) begin
      if (go_reset) begin
        mode_q       <= MODE_RESET;
        reset_pend_q <= 1'b0;
        halt_pend_q  <= 1'b0;
      end else if (reset_req_in) begin
        reset_pend_q <= 1'b1;
      end else if ((go_halt || busoff_halt) && !locked && mode_q == MODE_OPER) begin
        mode_q      <= MODE_HALT;
        halt_pend_q <= 1'b0;
      end else if (halt_req_in && mode_q == MODE_OPER) begin
        halt_pend_q <= 1'b1;
      end else if (oper_req_in && mode_q != MODE_OPER) begin
        mode_q      <= MODE_OPER;
        halt_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      force_q <= 1'b0;
    end else if (ce_in) begin
      force_q <= force_busoff_recovery_in && stat_q.busoff;
    end
  end

  assign diff = (rx_id_in ^ filter_id_in) & filter_mask_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      accept_q <= 1'b0;
    end else if (ce_in) begin
      accept_q <= rx_id_valid_in && (diff == '0);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_mode_out        <= MODE_RESET;
      bus_lock_flag_out  <= 1'b0;
      force_recovery_out <= 1'b0;
      accept_out         <= 1'b0;
      ctrl_status_out    <= 8'h00;
    end else if (ce_in) begin
      op_mode_out        <= mode_q;
      bus_lock_flag_out  <= lock_q;
      force_recovery_out <= force_q;
      accept_out         <= accept_q;
      ctrl_status_out    <= {3'h0, force_q, lock_q, busoff_recovery_mode_in, reset_pend_q | halt_pend_q};
    end
  end

  // Re-arm steps after a software clear
  sequence s_lock_cleared;
    ce_in && !armed_q && lock_q && bus_lock_clear_in;
  endsequence

  sequence s_reset_pass;
    (ce_in && wait_rearm_q && mode_q == MODE_RESET) ##1 (ce_in && mode_q == MODE_OPER);
  endsequence

  a_lock_needs_oper: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && $rose(lock_q) |-> $past(mode_q) == MODE_OPER)
    else $error("lock flag set outside operation");

  a_no_halt_locked: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && locked && mode_q == MODE_OPER |=> mode_q != MODE_HALT)
    else $error("halt entered while locked");

  a_tx_reset_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode_q == MODE_OPER && stat_q.transmitting && !stat_q.busoff && !frame_over && !stat_q.suspend_tx
    |=> mode_q != MODE_RESET)
    else $error("reset entered mid transmission");

  a_rx_reset_now: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reset_req_in && !stat_q.transmitting && !stat_q.suspend_tx |=> mode_q == MODE_RESET)
    else $error("reset not immediate for receiver");

  a_busoff_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && reset_req_in && stat_q.busoff |=> mode_q == MODE_RESET)
    else $error("reset not immediate in bus-off");

  a_auto_halt_01: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode_q == MODE_OPER && busoff_recovery_mode_in == RECOV_AUTO_NOW && stat_q.busoff
    && !locked && !go_reset |=> mode_q == MODE_HALT)
    else $error("no auto halt at bus-off");

  a_halt_00_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode_q == MODE_OPER && busoff_recovery_mode_in == RECOV_WAIT && stat_q.busoff
    && !stat_q.recovery_done |=> mode_q != MODE_HALT)
    else $error("halt before recovery end");

  a_accept_mask: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && rx_id_valid_in && filter_mask_in == '0 |=> accept_q)
    else $error("masked id rejected");

  a_std_mask_cmp: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && rx_id_valid_in && ((rx_id_in.std_id ^ filter_id_in.std_id) & filter_mask_in.std_id) != '0
    |=> !accept_q)
    else $error("compared std bit mismatch accepted");

  a_force_exit: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && force_busoff_recovery_in && stat_q.busoff ##1 ce_in |=> force_recovery_out)
    else $error("forced recovery not shown");

  a_status_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_status_out[7:5] == 3'h0)
    else $error("unused bits nonzero");

  a_clear_waits: assert property (@(posedge clk_in) disable iff (rst_in)
    s_lock_cleared |=> wait_rearm_q && !lock_q)
    else $error("lock clear not taken");

  a_rearm_recessive: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && wait_rearm_q && rx_sync_q |=> armed_q)
    else $error("recessive bit did not re-arm");

  a_rearm_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    s_reset_pass |=> armed_q)
    else $error("reset pass did not re-arm");

  a_rx_error_halt: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode_q == MODE_OPER && halt_pend_q && stat_q.receiving && stat_q.bus_error && !stat_q.busoff
    && !reset_req_in && !reset_pend_q && !locked |=> mode_q == MODE_HALT)
    else $error("rx error did not halt");

  a_tx_arb_halt: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode_q == MODE_OPER && halt_pend_q && stat_q.transmitting && stat_q.arb_lost && !stat_q.busoff
    && !reset_req_in && !reset_pend_q && !locked |=> mode_q == MODE_HALT)
    else $error("lost arbitration did not halt");

  a_suspend_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && (reset_req_in || reset_pend_q) && stat_q.suspend_tx && stat_q.bus_idle |=> mode_q == MODE_RESET)
    else $error("suspend reset missed idle bus");

  a_auto_halt_10: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode_q == MODE_OPER && busoff_recovery_mode_in == RECOV_AUTO_END && stat_q.busoff
    && stat_q.recovery_done && !locked && !go_reset |=> mode_q == MODE_HALT)
    else $error("no auto halt after recovery");

  a_auto_10_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode_q == MODE_OPER && busoff_recovery_mode_in == RECOV_AUTO_END && stat_q.busoff
    && !stat_q.recovery_done |=> mode_q != MODE_HALT)
    else $error("auto halt before recovery end");

  a_halt_req_now: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode_q == MODE_OPER && busoff_recovery_mode_in == RECOV_REQ_NOW && stat_q.busoff
    && (halt_req_in || halt_pend_q) && !locked && !go_reset |=> mode_q == MODE_HALT)
    else $error("requested halt not immediate");

endmodule

// [dv/can_far_node.sv]
`timescale 1ns/100ps
module can_far_node #(
  parameter int TICK_DIV = 4
) (
  input  wire logic clk_in,
  input  wire logic hold_dom_in,
  output logic      rx_out,
  output logic      tick_out
);
  int cnt_q = 0;
  // Released bus is biased recessive
  assign rx_out = hold_dom_in ? 1'b0 : 1'b1;
  assign tick_out = (cnt_q == 0);
  always @(posedge clk_in) begin
    cnt_q <= (cnt_q == TICK_DIV - 1) ? 0 : cnt_q + 1;
  end
endmodule

// [dv/can_mode_and_bus_lock_control_tb.sv]
`timescale 1ns/100ps
module can_mode_and_bus_lock_control_tb;
  import can_mode_pkg::*;
  logic           clk_in = 0;
  logic           rst_in = 1;
  logic           dom = 0;
  logic           rst_r = 0;
  logic           halt_r = 0;
  logic           oper_r = 0;
  logic           frc = 0;
  logic           clr = 0;
  logic           ce = 1;
  logic           idv = 0;
  logic [1:0]     busoff_recovery_mode = 2'h0;
  logic           rx_w;
  logic           tick_w;
  proto_stat_type st = '0;
  proto_stat_type st_w;
  can_id_type     rid = '0;
  can_id_type     msk = '0;
  logic [1:0]     mode;
  logic           lock;
  logic           fout;
  logic           acc;
  logic [7:0]     stat;
  int             mismatches = 0;
  int             cmp_count = 0;
  always #25 clk_in = ~clk_in;
  always_comb begin
    st_w = st;
    st_w.bit_tick = tick_w;
  end
  // Small lock count keeps the dominant runs short
  can_mode_and_bus_lock_control #(.LOCK_COUNT(4)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .can_rx_in(rx_w), .stat_in(st_w),
    .reset_req_in(rst_r), .halt_req_in(halt_r), .oper_req_in(oper_r),
    .busoff_recovery_mode_in(busoff_recovery_mode), .force_busoff_recovery_in(frc), .bus_lock_clear_in(clr),
    .rx_id_in(rid), .rx_id_valid_in(idv), .filter_id_in('0), .filter_mask_in(msk),
    .op_mode_out(mode), .bus_lock_flag_out(lock), .force_recovery_out(fout),
    .accept_out(acc), .ctrl_status_out(stat));
  can_far_node #(.TICK_DIV(4)) i_node (.clk_in(clk_in), .hold_dom_in(dom), .rx_out(rx_w), .tick_out(tick_w));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_in);
    s = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 10 && mode !== m; i++) @(negedge clk_in);
    chk("op_mode", m, mode);
  endtask
  task automatic stay_mode(input logic [1:0] m);
    repeat (6) begin
      @(negedge clk_in);
      chk("op_mode_held", m, mode);
    end
  endtask
  task automatic wait_lock;
    for (int i = 0; i < 60 && lock !== 1'b1; i++) @(negedge clk_in);
    chk("bus_lock_flag", 1, lock);
  endtask
  // One-cycle outputs are caught over a short window
  task automatic catch_pulse(input bit w, input logic e);
    logic v;
    v = 1'b0;
    repeat (3) begin
      @(negedge clk_in);
      v = v | (w ? fout : acc);
    end
    chk(w ? "force_recovery" : "accept", e, v);
  endtask
  task automatic filt(input can_id_type r, input can_id_type m, input logic e);
    rid = r;
    msk = m;
    idv = 1'b1;
    @(negedge clk_in);
    idv = 1'b0;
    catch_pulse(0, e);
  endtask
  task automatic to_oper;
    pulse(rst_r);
    wait_mode(2'h1);
    pulse(oper_r);
    wait_mode(2'h0);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(50ns * 4000);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge clk_in);
    rst_in = 0;
    chk("status_reset", 8'h00, stat);
    to_oper();
    filt('{11'h000, 18'h3FFFF}, '{11'h7FF, 18'h00000}, 1);
    filt('{11'h000, 18'h00001}, '{11'h000, 18'h00001}, 0);
    filt('{11'h7FF, 18'h00000}, '{11'h000, 18'h3FFFF}, 1);
    filt('{11'h400, 18'h00000}, '{11'h400, 18'h00000}, 0);
    dom = 1;
    wait_lock();
    chk("status_unused", 0, {5'h00, stat[7:5]});
    pulse(halt_r);
    stay_mode(2'h0);
    pulse(rst_r);
    wait_mode(2'h1);
    pulse(clr);
    chk("lock_cleared", 0, lock);
    pulse(oper_r);
    wait_mode(2'h0);
    wait_lock();
    pulse(clr);
    dom = 0;
    repeat (8) @(negedge clk_in);
    dom = 1;
    wait_lock();
    dom = 0;
    pulse(clr);
    to_oper();
    // Frozen clock enable must drop the request
    ce = 0;
    pulse(rst_r);
    stay_mode(2'h0);
    ce = 1;
    // Status is registered once, so it leads the request by a cycle
    st.transmitting = 1;
    @(negedge clk_in);
    pulse(rst_r);
    stay_mode(2'h0);
    st.frame_done = 1;
    @(negedge clk_in);
    st = '0;
    wait_mode(2'h1);
    to_oper();
    st.suspend_tx = 1;
    @(negedge clk_in);
    pulse(rst_r);
    stay_mode(2'h0);
    st.bus_idle = 1;
    @(negedge clk_in);
    st = '0;
    wait_mode(2'h1);
    to_oper();
    st.receiving = 1;
    @(negedge clk_in);
    pulse(halt_r);
    stay_mode(2'h0);
    st.bus_error = 1;
    @(negedge clk_in);
    st = '0;
    wait_mode(2'h2);
    to_oper();
    st.transmitting = 1;
    @(negedge clk_in);
    pulse(halt_r);
    stay_mode(2'h0);
    st.arb_lost = 1;
    @(negedge clk_in);
    st = '0;
    wait_mode(2'h2);
    to_oper();
    busoff_recovery_mode = RECOV_AUTO_NOW;
    st.busoff = 1;
    wait_mode(2'h2);
    frc = 1;
    @(negedge clk_in);
    frc = 0;
    catch_pulse(1, 1);
    st = '0;
    to_oper();
    busoff_recovery_mode = RECOV_AUTO_END;
    st.busoff = 1;
    stay_mode(2'h0);
    st.recovery_done = 1;
    @(negedge clk_in);
    st = '0;
    wait_mode(2'h2);
    to_oper();
    busoff_recovery_mode = RECOV_REQ_NOW;
    st.busoff = 1;
    @(negedge clk_in);
    pulse(halt_r);
    wait_mode(2'h2);
    st = '0;
    to_oper();
    busoff_recovery_mode = RECOV_WAIT;
    st.busoff = 1;
    @(negedge clk_in);
    pulse(halt_r);
    stay_mode(2'h0);
    st.recovery_done = 1;
    @(negedge clk_in);
    st = '0;
    wait_mode(2'h2);
    to_oper();
    st.busoff = 1;
    st.transmitting = 1;
    @(negedge clk_in);
    pulse(rst_r);
    wait_mode(2'h1);
    st = '0;
    print_verdict();
  end
endmodule
